// File: src/ffb_pkg.sv
// Purpose: Shared constants for the free function block set.
// Assumes: 10 MHz system clock, APB slave with 32-bit data.
// Notes:   Numeric values are signed Q16.16; the full 32-bit range stands in for +/-3.4E38.
package ffb_pkg;
  // Clock and time slices
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned SLICE_BASE_MS    = 8;
  localparam int unsigned BASE_TICK_CYCLES = (CLK_HZ / 1000) * SLICE_BASE_MS;
  localparam int unsigned GROUP_COUNT      = 6;
  localparam logic [2:0]  GROUP_MIN        = 3'h1;
  localparam logic [2:0]  GROUP_MAX        = 3'h6;
  localparam int unsigned RUN_SEQ_MAX      = 32000;

  // Numeric format
  localparam int unsigned        FRAC_BITS = 16;
  localparam logic signed [31:0] VAL_MAX   = 32'sh7FFFFFFF;
  localparam logic signed [31:0] VAL_MIN   = 32'sh80000000;
  localparam logic [15:0]        FRAC_ZERO = 16'h0000;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_BIN_IN      = 8'h04;
  localparam logic [7:0] OFS_NUM_A       = 8'h08;
  localparam logic [7:0] OFS_NUM_B       = 8'h0C;
  localparam logic [7:0] OFS_DERIV_TIME  = 8'h10;
  localparam logic [7:0] OFS_INT_TIME    = 8'h14;
  localparam logic [7:0] OFS_LOWER_BOUND = 8'h18;
  localparam logic [7:0] OFS_UPPER_BOUND = 8'h1C;
  localparam logic [7:0] OFS_PRESET      = 8'h20;
  localparam logic [7:0] OFS_CLAMP_FLOOR = 8'h24;
  localparam logic [7:0] OFS_CLAMP_CEIL  = 8'h28;
  localparam logic [7:0] OFS_TIMER_T     = 8'h2C;
  localparam logic [7:0] OFS_BIN_OUT     = 8'h30;
  localparam logic [7:0] OFS_QUOTIENT    = 8'h34;
  localparam logic [7:0] OFS_INT_QUOT    = 8'h38;
  localparam logic [7:0] OFS_REMAINDER   = 8'h3C;
  localparam logic [7:0] OFS_DERIV_OUT   = 8'h40;
  localparam logic [7:0] OFS_INTEG_OUT   = 8'h44;
  localparam logic [7:0] OFS_CLAMP_OUT   = 8'h48;
  localparam logic [7:0] OFS_SWITCH_OUT  = 8'h4C;

  // Binary input bits
  localparam int unsigned BI_LATCH_D   = 0;
  localparam int unsigned BI_LATCH_TRG = 1;
  localparam int unsigned BI_LATCH_SET = 2;
  localparam int unsigned BI_LATCH_RST = 3;
  localparam int unsigned BI_INV       = 4;
  localparam int unsigned BI_SEL       = 5;
  localparam int unsigned BI_OR_LO     = 6;
  localparam int unsigned BI_PULSE     = 10;
  localparam int unsigned BI_TRIM      = 11;
  localparam int unsigned BI_ON        = 12;
  localparam int unsigned BI_OFF       = 13;
  localparam int unsigned BI_INT_SET   = 14;
  localparam int unsigned BI_WIDTH     = 15;

  // Binary output bits
  localparam int unsigned BO_LATCH_Q  = 0;
  localparam int unsigned BO_LATCH_QN = 1;
  localparam int unsigned BO_FAULT    = 2;
  localparam int unsigned BO_ABOVE    = 3;
  localparam int unsigned BO_EQUAL    = 4;
  localparam int unsigned BO_BELOW    = 5;
  localparam int unsigned BO_INV      = 6;
  localparam int unsigned BO_OR       = 7;
  localparam int unsigned BO_PULSE    = 8;
  localparam int unsigned BO_TRIM     = 9;
  localparam int unsigned BO_ON       = 10;
  localparam int unsigned BO_OFF      = 11;
  localparam int unsigned BO_WIDTH    = 12;
endpackage : ffb_pkg

// File: src/ffb_top.sv
// Purpose: Free function block set evaluated once per runtime-group time slice.
// Assumes: All block inputs come from APB registers; outputs are read back over APB.
// Notes:   One runtime group serves every block; a group of 0 or above 6 stops evaluation.
// How it works
// - Latch is reset dominant: set gives 1/0, reset gives 0/1 always.
// - Trigger high with set and reset low loads data; all low holds.
// - Derivative output is sample difference times derivative time over slice time.
// - Quotient is first input over second, saturated to the value range.
// - Zero divided by zero leaves the quotient unchanged.
// - Integer quotient and remainder, remainder being (quotient minus integer) times first.
// - Range fault flag is 1 on overflow or a zero divisor.
// - Integrator adds input times slice time over time constant each slice.
// - Integrator sum is clamped between lower and upper bound; the preset value is loaded unclamped.
// - Clamp block passes its input limited to floor and ceiling.
// - Fixed pulse timer gives 1 for exactly its duration after a rising edge.
// - Fixed pulse timer ignores rising edges while its pulse runs.
// - Comparator raises exactly one of above, equal and below.
// - Inverter outputs the complement of its input.
// - Select switch outputs first input on 0, second on 1.
// - Four-input OR is 0 only when all inputs are 0.
// - Pulse trim sets on rising edge, clears on low input or expiry.
// - Turn-on delay rises after the delay from a rising edge, clears on low input.
// - Turn-off delay is 1 while input is 1, clears a delay after fall.
// - Input returning to 1 during the turn-off delay cancels the clearing.
// - Blocks run once per slice of 8, 16, 32, 64, 128 or 256 ms.
// - Within a slice all blocks are computed together on the same tick from the register values.
`timescale 1ns/1ps
module ffb_top #(
  parameter int unsigned BASE_TICK_CYCLES = ffb_pkg::BASE_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // Software-written configuration
  logic        [2:0]                   group_reg;
  logic        [ffb_pkg::BI_WIDTH-1:0] bin_in_reg;
  logic signed [31:0]                  num_a_reg;
  logic signed [31:0]                  num_b_reg;
  logic        [15:0]                  deriv_time_reg;
  logic        [15:0]                  int_time_reg;
  logic signed [31:0]                  lower_bound_reg;
  logic signed [31:0]                  upper_bound_reg;
  logic signed [31:0]                  preset_reg;
  logic signed [31:0]                  clamp_floor_reg;
  logic signed [31:0]                  clamp_ceil_reg;
  logic        [31:0]                  timer_t_reg;

  // Block state and outputs
  logic        [ffb_pkg::BO_PULSE-1:0] bin_out_reg;
  logic        [ffb_pkg::BO_WIDTH-1:ffb_pkg::BO_PULSE] timer_out_reg;
  logic signed [31:0]                  quotient_reg;
  logic signed [31:0]                  int_quot_reg;
  logic signed [31:0]                  remainder_reg;
  logic signed [31:0]                  deriv_out_reg;
  logic signed [31:0]                  prev_a_reg;
  logic signed [31:0]                  integ_out_reg;
  logic signed [31:0]                  clamp_out_reg;
  logic signed [31:0]                  switch_out_reg;
  logic        [ffb_pkg::BI_WIDTH-1:0] prev_in_reg;
  logic        [7:0]                   tcnt_reg [4];

  // Tick generation
  logic [31:0] base_cnt_reg;
  logic [4:0]  div_cnt_reg;
  logic        base_tick;
  logic [4:0]  group_mask;
  logic        tick;

  // APB decode
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic [31:0] rd_mux;

  // Saturate a wide value into the 32-bit range
  function automatic logic signed [31:0] sat32(input logic signed [63:0] v);
    if (v > 64'(ffb_pkg::VAL_MAX)) begin
      return ffb_pkg::VAL_MAX;
    end else if (v < 64'(ffb_pkg::VAL_MIN)) begin
      return ffb_pkg::VAL_MIN;
    end
    return v[31:0];
  endfunction : sat32

  // Base tick every 8 ms, group tick every 2^(group-1) base ticks
  assign base_tick  = (base_cnt_reg == BASE_TICK_CYCLES - 1);
  assign group_mask = 5'((6'h01 << (group_reg - ffb_pkg::GROUP_MIN)) - 6'h01);
  assign tick       = base_tick && (group_reg >= ffb_pkg::GROUP_MIN)
                      && (group_reg <= ffb_pkg::GROUP_MAX)
                      && ((div_cnt_reg & group_mask) == 5'h00);

  always_ff @(posedge clk_sys) begin
    if (rst || base_tick) begin
      base_cnt_reg <= 32'h00000000;
    end else begin
      base_cnt_reg <= base_cnt_reg + 32'h00000001;
    end
  end

  // Slice divider, wraps at 32 base ticks (256 ms)
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt_reg <= 5'h00;
    end else if (base_tick) begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  // Zero-wait APB slave
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable;
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h00000000;
    unique case (paddr)
      ffb_pkg::OFS_CTRL:        rd_mux = {29'h0, group_reg};
      ffb_pkg::OFS_BIN_IN:      rd_mux = 32'(bin_in_reg);
      ffb_pkg::OFS_NUM_A:       rd_mux = num_a_reg;
      ffb_pkg::OFS_NUM_B:       rd_mux = num_b_reg;
      ffb_pkg::OFS_DERIV_TIME:  rd_mux = {16'h0, deriv_time_reg};
      ffb_pkg::OFS_INT_TIME:    rd_mux = {16'h0, int_time_reg};
      ffb_pkg::OFS_LOWER_BOUND: rd_mux = lower_bound_reg;
      ffb_pkg::OFS_UPPER_BOUND: rd_mux = upper_bound_reg;
      ffb_pkg::OFS_PRESET:      rd_mux = preset_reg;
      ffb_pkg::OFS_CLAMP_FLOOR: rd_mux = clamp_floor_reg;
      ffb_pkg::OFS_CLAMP_CEIL:  rd_mux = clamp_ceil_reg;
      ffb_pkg::OFS_TIMER_T:     rd_mux = timer_t_reg;
      ffb_pkg::OFS_BIN_OUT:     rd_mux = 32'({timer_out_reg, bin_out_reg});
      ffb_pkg::OFS_QUOTIENT:    rd_mux = quotient_reg;
      ffb_pkg::OFS_INT_QUOT:    rd_mux = int_quot_reg;
      ffb_pkg::OFS_REMAINDER:   rd_mux = remainder_reg;
      ffb_pkg::OFS_DERIV_OUT:   rd_mux = deriv_out_reg;
      ffb_pkg::OFS_INTEG_OUT:   rd_mux = integ_out_reg;
      ffb_pkg::OFS_CLAMP_OUT:   rd_mux = clamp_out_reg;
      ffb_pkg::OFS_SWITCH_OUT:  rd_mux = switch_out_reg;
      default:                  addr_ok = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      group_reg       <= 3'h0;
      bin_in_reg      <= '0;
      num_a_reg       <= 32'sh00000000;
      num_b_reg       <= 32'sh00000000;
      deriv_time_reg  <= 16'h0000;
      int_time_reg    <= 16'h0001;
      lower_bound_reg <= ffb_pkg::VAL_MIN;
      upper_bound_reg <= ffb_pkg::VAL_MAX;
      preset_reg      <= 32'sh00000000;
      clamp_floor_reg <= ffb_pkg::VAL_MIN;
      clamp_ceil_reg  <= ffb_pkg::VAL_MAX;
      timer_t_reg     <= 32'h00000000;
    end else if (wr_en) begin
      unique case (paddr)
        ffb_pkg::OFS_CTRL:        group_reg       <= pwdata[2:0];
        ffb_pkg::OFS_BIN_IN:      bin_in_reg      <= pwdata[ffb_pkg::BI_WIDTH-1:0];
        ffb_pkg::OFS_NUM_A:       num_a_reg       <= pwdata;
        ffb_pkg::OFS_NUM_B:       num_b_reg       <= pwdata;
        ffb_pkg::OFS_DERIV_TIME:  deriv_time_reg  <= pwdata[15:0];
        ffb_pkg::OFS_INT_TIME:    int_time_reg    <= pwdata[15:0];
        ffb_pkg::OFS_LOWER_BOUND: lower_bound_reg <= pwdata;
        ffb_pkg::OFS_UPPER_BOUND: upper_bound_reg <= pwdata;
        ffb_pkg::OFS_PRESET:      preset_reg      <= pwdata;
        ffb_pkg::OFS_CLAMP_FLOOR: clamp_floor_reg <= pwdata;
        ffb_pkg::OFS_CLAMP_CEIL:  clamp_ceil_reg  <= pwdata;
        ffb_pkg::OFS_TIMER_T:     timer_t_reg     <= pwdata;
        default:                  ;
      endcase
    end
  end

  // Divider arithmetic
  logic signed [63:0] div_num;
  logic signed [63:0] div_q;
  logic               div_zero;
  logic               div_ovf;
  logic signed [31:0] quot_next;
  logic signed [31:0] quot_mag;
  logic signed [31:0] int_quot_next;
  logic signed [63:0] rem_prod;

  assign div_num  = {{16{num_a_reg[31]}}, num_a_reg, ffb_pkg::FRAC_ZERO};
  assign div_zero = (num_b_reg == 32'sh00000000);
  assign div_q    = div_zero ? 64'sh0 : div_num / 64'(num_b_reg);
  assign div_ovf  = (div_q > 64'(ffb_pkg::VAL_MAX)) || (div_q < 64'(ffb_pkg::VAL_MIN));

  always_comb begin
    if (div_zero && (num_a_reg == 32'sh00000000)) begin
      quot_next = quotient_reg;
    end else if (div_zero) begin
      quot_next = num_a_reg[31] ? ffb_pkg::VAL_MIN : ffb_pkg::VAL_MAX;
    end else begin
      quot_next = sat32(div_q);
    end
    quot_mag      = quot_next[31] ? -quot_next : quot_next;
    int_quot_next = quot_next[31] ? -{quot_mag[31:16], ffb_pkg::FRAC_ZERO}
                                  : {quot_mag[31:16], ffb_pkg::FRAC_ZERO};
    rem_prod      = (64'(quot_next - int_quot_next) * 64'(num_a_reg))
                    >>> ffb_pkg::FRAC_BITS;
  end

  // Divider outputs, all blocks update together on the same tick
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      quotient_reg  <= 32'sh00000000;
      int_quot_reg  <= 32'sh00000000;
      remainder_reg <= 32'sh00000000;
    end else if (tick) begin
      quotient_reg  <= quot_next;
      int_quot_reg  <= int_quot_next;
      remainder_reg <= sat32(rem_prod);
    end
  end

  // Derivative and integrator
  logic signed [63:0] integ_sum;
  logic signed [31:0] integ_sat;
  logic [15:0]        ti_ticks;

  assign ti_ticks  = (int_time_reg == 16'h0000) ? 16'h0001 : int_time_reg;
  assign integ_sum = 64'(integ_out_reg) + 64'(num_a_reg) / $signed(64'(ti_ticks));
  assign integ_sat = sat32(integ_sum);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_a_reg    <= 32'sh00000000;
      deriv_out_reg <= 32'sh00000000;
      integ_out_reg <= 32'sh00000000;
    end else if (tick) begin
      prev_a_reg    <= num_a_reg;
      deriv_out_reg <= sat32((64'(num_a_reg) - 64'(prev_a_reg))
                             * 64'(deriv_time_reg));
      if (bin_in_reg[ffb_pkg::BI_INT_SET]) begin
        integ_out_reg <= preset_reg;
      end else if (integ_sat < lower_bound_reg) begin
        integ_out_reg <= lower_bound_reg;
      end else if (integ_sat > upper_bound_reg) begin
        integ_out_reg <= upper_bound_reg;
      end else begin
        integ_out_reg <= integ_sat;
      end
    end
  end

  // Clamp block and numeric select switch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clamp_out_reg  <= 32'sh00000000;
      switch_out_reg <= 32'sh00000000;
    end else if (tick) begin
      if (num_a_reg < clamp_floor_reg) begin
        clamp_out_reg <= clamp_floor_reg;
      end else if (num_a_reg > clamp_ceil_reg) begin
        clamp_out_reg <= clamp_ceil_reg;
      end else begin
        clamp_out_reg <= num_a_reg;
      end
      switch_out_reg <= bin_in_reg[ffb_pkg::BI_SEL] ? num_b_reg : num_a_reg;
    end
  end

  // Latch, logic gates, comparator and fault flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bin_out_reg <= 8'h02;
    end else if (tick) begin
      if (bin_in_reg[ffb_pkg::BI_LATCH_RST]) begin
        bin_out_reg[ffb_pkg::BO_LATCH_Q]  <= 1'b0;
        bin_out_reg[ffb_pkg::BO_LATCH_QN] <= 1'b1;
      end else if (bin_in_reg[ffb_pkg::BI_LATCH_SET]) begin
        bin_out_reg[ffb_pkg::BO_LATCH_Q]  <= 1'b1;
        bin_out_reg[ffb_pkg::BO_LATCH_QN] <= 1'b0;
      end else if (bin_in_reg[ffb_pkg::BI_LATCH_TRG]) begin
        bin_out_reg[ffb_pkg::BO_LATCH_Q]  <= bin_in_reg[ffb_pkg::BI_LATCH_D];
        bin_out_reg[ffb_pkg::BO_LATCH_QN] <= !bin_in_reg[ffb_pkg::BI_LATCH_D];
      end
      bin_out_reg[ffb_pkg::BO_FAULT] <= div_zero || div_ovf;
      bin_out_reg[ffb_pkg::BO_ABOVE] <= num_a_reg > num_b_reg;
      bin_out_reg[ffb_pkg::BO_EQUAL] <= num_a_reg == num_b_reg;
      bin_out_reg[ffb_pkg::BO_BELOW] <= num_a_reg < num_b_reg;
      bin_out_reg[ffb_pkg::BO_INV]   <= !bin_in_reg[ffb_pkg::BI_INV];
      bin_out_reg[ffb_pkg::BO_OR]    <= |bin_in_reg[ffb_pkg::BI_OR_LO +: 4];
    end
  end

  // Timers: durations in slice ticks, edges against last tick's sample
  logic [7:0] dur [4];
  logic [3:0] tin;
  logic [3:0] trise;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_timer
      assign dur[gi]   = timer_t_reg[gi*8 +: 8];
      assign tin[gi]   = bin_in_reg[ffb_pkg::BI_PULSE + gi];
      assign trise[gi] = tin[gi] && !prev_in_reg[ffb_pkg::BI_PULSE + gi];
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_in_reg <= '0;
    end else if (tick) begin
      prev_in_reg <= bin_in_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        tcnt_reg[i] <= 8'h00;
      end
      timer_out_reg <= 4'h0;
    end else if (tick) begin
      // Fixed pulse: edges ignored while running
      if (!timer_out_reg[ffb_pkg::BO_PULSE]) begin
        if (trise[0] && dur[0] != 8'h00) begin
          timer_out_reg[ffb_pkg::BO_PULSE] <= 1'b1;
          tcnt_reg[0] <= dur[0] - 8'h01;
        end
      end else if (tcnt_reg[0] == 8'h00) begin
        timer_out_reg[ffb_pkg::BO_PULSE] <= 1'b0;
      end else begin
        tcnt_reg[0] <= tcnt_reg[0] - 8'h01;
      end
      // Pulse trim
      if (trise[1] && dur[1] != 8'h00) begin
        timer_out_reg[ffb_pkg::BO_TRIM] <= 1'b1;
        tcnt_reg[1] <= dur[1] - 8'h01;
      end else if (!tin[1] || tcnt_reg[1] == 8'h00) begin
        timer_out_reg[ffb_pkg::BO_TRIM] <= 1'b0;
      end else begin
        tcnt_reg[1] <= tcnt_reg[1] - 8'h01;
      end
      // Turn-on delay, reloaded while input is low
      if (!tin[2]) begin
        timer_out_reg[ffb_pkg::BO_ON] <= 1'b0;
        tcnt_reg[2] <= dur[2];
      end else if (tcnt_reg[2] == 8'h00) begin
        timer_out_reg[ffb_pkg::BO_ON] <= 1'b1;
      end else begin
        tcnt_reg[2] <= tcnt_reg[2] - 8'h01;
      end
      // Turn-off delay, reloaded while input is high
      if (tin[3]) begin
        timer_out_reg[ffb_pkg::BO_OFF] <= 1'b1;
        tcnt_reg[3] <= dur[3];
      end else if (tcnt_reg[3] == 8'h00) begin
        timer_out_reg[ffb_pkg::BO_OFF] <= 1'b0;
      end else begin
        tcnt_reg[3] <= tcnt_reg[3] - 8'h01;
      end
    end
  end

  // Reset-dominant latch outputs stay complementary after a tick
  chk_latch_reset_wins: assert property (@(posedge clk_sys) disable iff (rst)
    tick && bin_in_reg[ffb_pkg::BI_LATCH_RST] |=>
      !bin_out_reg[ffb_pkg::BO_LATCH_Q] && bin_out_reg[ffb_pkg::BO_LATCH_QN])
    else $error("latch reset did not dominate");

  chk_latch_data_load: assert property (@(posedge clk_sys) disable iff (rst)
    tick && bin_in_reg[ffb_pkg::BI_LATCH_TRG] && !bin_in_reg[ffb_pkg::BI_LATCH_SET]
      && !bin_in_reg[ffb_pkg::BI_LATCH_RST] |=>
      bin_out_reg[ffb_pkg::BO_LATCH_Q] == $past(bin_in_reg[ffb_pkg::BI_LATCH_D]))
    else $error("latch did not load data");

  chk_div_hold_zero: assert property (@(posedge clk_sys) disable iff (rst)
    tick && div_zero && num_a_reg == 32'sh00000000 |=> $stable(quotient_reg))
    else $error("0/0 changed the quotient");

  chk_div_fault_flag: assert property (@(posedge clk_sys) disable iff (rst)
    tick && div_zero |=> bin_out_reg[ffb_pkg::BO_FAULT])
    else $error("zero divisor without fault");

  chk_integ_preset: assert property (@(posedge clk_sys) disable iff (rst)
    tick && bin_in_reg[ffb_pkg::BI_INT_SET] |=> integ_out_reg == $past(preset_reg))
    else $error("integrator ignored preset");

  chk_compare_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $past(tick) |-> $onehot(bin_out_reg[ffb_pkg::BO_BELOW:ffb_pkg::BO_ABOVE]))
    else $error("comparator flags not one-hot");

  chk_pulse_no_retrig: assert property (@(posedge clk_sys) disable iff (rst)
    tick && timer_out_reg[ffb_pkg::BO_PULSE] && tcnt_reg[0] != 8'h00 |=>
      tcnt_reg[0] == $past(tcnt_reg[0]) - 8'h01)
    else $error("pulse restarted while running");

  chk_on_delay_clear: assert property (@(posedge clk_sys) disable iff (rst)
    tick && !tin[2] |=> !timer_out_reg[ffb_pkg::BO_ON])
    else $error("turn-on output not cleared");

  chk_off_delay_hold: assert property (@(posedge clk_sys) disable iff (rst)
    tick && tin[3] |=> timer_out_reg[ffb_pkg::BO_OFF] && tcnt_reg[3] == $past(dur[3]))
    else $error("turn-off delay not rearmed");

  chk_tick_period: assert property (@(posedge clk_sys) disable iff (rst)
    base_tick |=> !base_tick [*2])
    else $error("base tick too frequent");

endmodule : ffb_top

// File: bench/tb_top.sv
// Purpose: Self-checking bench for the function block set over APB.
// Assumes: Group 1 with a 4-cycle base tick, so 48 cycles span 12 ticks.
// Notes:   Table rows cover the combinational blocks; the rest are hand tests.
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          mismatches, samples_checked;
  // Rows: a, b, bin_in, bin_out bits 7:2, switch, clamp, quotient
  logic [31:0] rows [4][7];
  logic [15:0] lat_in  [5] = '{16'h000C, 16'h0004, 16'h0000, 16'h0002, 16'h0003};
  logic [31:0] lat_exp [5] = '{32'h2, 32'h1, 32'h1, 32'h2, 32'h1};
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  ffb_top #(.BASE_TICK_CYCLES(4)) DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Verdict and end of run
  task automatic summarize;
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      $display("CHECK FAILED %0t apb wait ran out", $time);
      summarize();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // Read a register and compare the masked value
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp, $sformatf("reg %h", a));
  endtask : rdchk
  // Read until the masked value shows, a bounded number of times
  task automatic rdpoll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== exp && n < 8);
    chk(rd & m, exp, $sformatf("poll %h", a));
  endtask : rdpoll
  task automatic settle;
    repeat (48) @(posedge clk_sys);
  endtask : settle
  // Main sequence
  initial begin
    rows[0] = '{32'h00030000, 32'h00010000, 32'h000, 32'h48,
                32'h00030000, 32'h00020000, 32'h00030000};
    rows[1] = '{32'hFFFF0000, 32'h00020000, 32'h230, 32'hA0,
                32'h00020000, 32'hFFFF0000, 32'hFFFF8000};
    rows[2] = '{32'h00010000, 32'h00010000, 32'h040, 32'hD0,
                32'h00010000, 32'h00010000, 32'h00010000};
    rows[3] = '{32'hFFFD0000, 32'hFFFF0000, 32'h180, 32'hE0,
                32'hFFFD0000, 32'hFFFE0000, 32'h00030000};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(ffb_pkg::OFS_BIN_OUT, 32'hFFFFFFFF, 32'h2);
    rdchk(ffb_pkg::OFS_LOWER_BOUND, 32'hFFFFFFFF, 32'h80000000);
    apb(1'b0, 8'h50, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    apb(1'b1, ffb_pkg::OFS_CLAMP_FLOOR, 32'hFFFE0000);
    apb(1'b1, ffb_pkg::OFS_CLAMP_CEIL, 32'h00020000);
    apb(1'b1, ffb_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ffb_pkg::OFS_NUM_A, rows[i][0]);
      apb(1'b1, ffb_pkg::OFS_NUM_B, rows[i][1]);
      apb(1'b1, ffb_pkg::OFS_BIN_IN, rows[i][2]);
      settle();
      rdchk(ffb_pkg::OFS_BIN_OUT, 32'hFC, rows[i][3]);
      rdchk(ffb_pkg::OFS_SWITCH_OUT, 32'hFFFFFFFF, rows[i][4]);
      rdchk(ffb_pkg::OFS_CLAMP_OUT, 32'hFFFFFFFF, rows[i][5]);
      rdchk(ffb_pkg::OFS_QUOTIENT, 32'hFFFFFFFF, rows[i][6]);
    end
    apb(1'b1, ffb_pkg::OFS_NUM_A, 32'hFFFF0000);
    apb(1'b1, ffb_pkg::OFS_NUM_B, 32'h00020000);
    settle();
    rdchk(ffb_pkg::OFS_INT_QUOT, 32'hFFFFFFFF, 32'h0);
    rdchk(ffb_pkg::OFS_REMAINDER, 32'hFFFFFFFF, 32'h00008000);
    // Zero divisor saturates, then zero over zero holds the quotient
    apb(1'b1, ffb_pkg::OFS_NUM_A, 32'h00010000);
    apb(1'b1, ffb_pkg::OFS_NUM_B, 32'h0);
    settle();
    rdchk(ffb_pkg::OFS_QUOTIENT, 32'hFFFFFFFF, 32'h7FFFFFFF);
    rdchk(ffb_pkg::OFS_BIN_OUT, 32'h4, 32'h4);
    apb(1'b1, ffb_pkg::OFS_NUM_A, 32'hFFFF0000);
    settle();
    rdchk(ffb_pkg::OFS_QUOTIENT, 32'hFFFFFFFF, 32'h80000000);
    apb(1'b1, ffb_pkg::OFS_NUM_A, 32'h0);
    settle();
    rdchk(ffb_pkg::OFS_QUOTIENT, 32'hFFFFFFFF, 32'h80000000);
    // Integrator preset, then ramp into the upper bound
    apb(1'b1, ffb_pkg::OFS_PRESET, 32'h00050000);
    apb(1'b1, ffb_pkg::OFS_BIN_IN, 32'h4000);
    settle();
    rdchk(ffb_pkg::OFS_INTEG_OUT, 32'hFFFFFFFF, 32'h00050000);
    apb(1'b1, ffb_pkg::OFS_UPPER_BOUND, 32'h00060000);
    apb(1'b1, ffb_pkg::OFS_NUM_A, 32'h00010000);
    apb(1'b1, ffb_pkg::OFS_BIN_IN, 32'h0);
    settle();
    rdchk(ffb_pkg::OFS_INTEG_OUT, 32'hFFFFFFFF, 32'h00060000);
    // A step of 2.0 shows for one tick as 2.0 times derivative time
    apb(1'b1, ffb_pkg::OFS_DERIV_TIME, 32'h3);
    apb(1'b1, ffb_pkg::OFS_NUM_A, 32'h00030000);
    rdpoll(ffb_pkg::OFS_DERIV_OUT, 32'hFFFFFFFF, 32'h00060000);
    // Latch: reset dominance, set, hold, trigger loads
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, ffb_pkg::OFS_BIN_IN, {16'h0, lat_in[i]});
      settle();
      rdchk(ffb_pkg::OFS_BIN_OUT, 32'h3, lat_exp[i]);
    end
    // Timers of two ticks each
    apb(1'b1, ffb_pkg::OFS_TIMER_T, 32'h02020202);
    apb(1'b1, ffb_pkg::OFS_BIN_IN, 32'h3C00);
    rdpoll(ffb_pkg::OFS_BIN_OUT, 32'h300, 32'h300);
    settle();
    rdchk(ffb_pkg::OFS_BIN_OUT, 32'hF00, 32'hC00);
    apb(1'b1, ffb_pkg::OFS_BIN_IN, 32'h0);
    apb(1'b1, ffb_pkg::OFS_BIN_IN, 32'h2000);
    settle();
    rdchk(ffb_pkg::OFS_BIN_OUT, 32'hF00, 32'h800);
    apb(1'b1, ffb_pkg::OFS_BIN_IN, 32'h0);
    settle();
    rdchk(ffb_pkg::OFS_BIN_OUT, 32'hF00, 32'h000);
    summarize();
  end
endmodule : tb_top
